// File: design/irsp_pkg.sv
package irsp_pkg;

  // byte framing on the serial link
  localparam int         IRSP_BYTE_W     = 8;
  localparam logic [3:0] IRSP_ACK_SLOT   = 4'h8;      // count after eight data bits
  localparam logic [3:0] IRSP_CNT_RST    = 4'h0;

  // fixed upper six bits of the seven-bit slave address (binary 101110)
  localparam logic [5:0] IRSP_ADDR_UPPER = 6'h2e;

  // reset values, pointer step and read MSB index
  localparam logic [7:0] IRSP_PTR_RST    = 8'h00;
  localparam logic [7:0] IRSP_SHIFT_RST  = 8'h00;
  localparam logic [7:0] IRSP_RDATA_RST  = 8'hff;
  localparam logic [2:0] IRSP_IDX_RST    = 3'h0;
  localparam logic [7:0] IRSP_PTR_STEP   = 8'h01;
  localparam logic [2:0] IRSP_MSB_IDX    = 3'h7;

  // link-side byte phases
  typedef enum logic [2:0]
  {
    ST_ADDR,
    ST_SUB,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } irsp_state_type;

  // one register access handed from the link to the core side
  typedef struct packed
  {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } irsp_req_type;

  localparam irsp_req_type IRSP_REQ_RST = '0;

endpackage

// File: design/irsp_sync.sv
module irsp_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk_i,   // core clock
  input  wire logic             rst_b_i,  // async reset, active low
  input  wire logic             ce_i,     // clock enable
  input  wire logic [WIDTH-1:0] async_i,  // foreign-domain level
  output logic      [WIDTH-1:0] sync_o    // level in core domain
);
  import irsp_pkg::*;

  logic [WIDTH-1:0] meta_q;

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else if (ce_i)
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // irsp_sync

// File: design/irsp_cond_detect.sv
module irsp_cond_detect
(
  input  wire logic mclk_i,   // core clock
  input  wire logic rst_b_i,  // async reset, active low
  input  wire logic ce_i,     // clock enable
  input  wire logic scl_s_i,  // synchronised clock line
  input  wire logic sda_s_i,  // synchronised data line
  output logic      start_o,  // one-cycle start pulse
  output logic      stop_o    // one-cycle stop pulse
);
  import irsp_pkg::*;

  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_hi;

  // clock must be high on both samples, so a data edge made by
  // our own driver just after a falling clock is never mistaken
  assign scl_hi = scl_prev_q & scl_s_i;

  // previous samples of both lines
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_prev_q <= 1'b0;
      sda_prev_q <= 1'b0;
    end
    else if (ce_i)
    begin
      scl_prev_q <= scl_s_i;
      sda_prev_q <= sda_s_i;
    end
  end

  // data falling under high clock is a start, rising is a stop
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      start_o <= 1'b0;
      stop_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      start_o <= scl_hi & sda_prev_q & ~sda_s_i;
      stop_o  <= scl_hi & ~sda_prev_q & sda_s_i;
    end
  end

endmodule // irsp_cond_detect

// File: design/irsp_slave_port.sv
module irsp_slave_port
(
  input  wire logic                   mclk_i,                    // core clock
  input  wire logic                   rst_b_i,                   // async reset, low
  input  wire logic                   ce_i,                      // core clock enable
  input  wire logic                   serial_clock_pin_i,        // link clock line
  output logic                        serial_clock_pin_o,        // clock drive level
  output logic                        serial_clock_pin_oe_o,     // clock held low
  input  wire logic                   serial_data_pin_i,         // data line level
  output logic                        serial_data_pin_o,         // data drive level
  output logic                        serial_data_pin_oe_o,      // data pulled low
  input  wire logic                   slave_address_select_pin_i, // address strap
  output irsp_pkg::irsp_req_type      reg_req_o,                 // access request
  output logic                        reg_valid_o,               // request pending
  input  wire logic                   reg_ready_i,               // core takes it
  input  wire logic [7:0]             reg_rdata_i                // read data
);
  import irsp_pkg::*;

  // link clock domain
  logic           link_rst_b;
  logic           scl;
  logic           sda_in;
  irsp_state_type state_q;
  logic [3:0]     cnt_q;
  logic [7:0]     shift_q;
  logic [7:0]     ptr_q;
  irsp_req_type   req_q;
  logic           req_tgl_q;
  logic           strap_meta_q;
  logic           strap_q;
  logic           drive_ack_q;
  logic           rd_phase_q;
  logic [2:0]     idx_q;
  logic           at_ack;
  logic           addr_hit;
  logic           issue_wr;
  logic           issue_rd;
  logic           ack_due;

  // core clock domain
  logic [2:0]     sync_in;
  logic [2:0]     sync_out;
  logic           scl_s;
  logic           sda_s;
  logic           req_tgl_s;
  logic           ack_tgl_q;
  logic           busy;
  logic [7:0]     rd_data_q;
  logic           cond_start;
  logic           cond_stop;
  logic           frame_clr_q;

  assign scl    = serial_clock_pin_i;
  assign sda_in = serial_data_pin_i;

  // pin lines and the request toggle enter the core domain here
  assign sync_in   = {req_tgl_q, sda_in, scl};
  assign scl_s     = sync_out[0];
  assign sda_s     = sync_out[1];
  assign req_tgl_s = sync_out[2];

  irsp_sync
  #(
    .WIDTH (3)
  )
  u_sync
  (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .async_i (sync_in),
    .sync_o  (sync_out)
  );

  irsp_cond_detect u_cond
  (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .scl_s_i (scl_s),
    .sda_s_i (sda_s),
    .start_o (cond_start),
    .stop_o  (cond_stop)
  );

  // start or stop re-arms the link logic; the link clock stands still
  // while the clock line is high, so only an async clear can end a frame
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      frame_clr_q <= 1'b0;
    end
    else if (ce_i)
    begin
      frame_clr_q <= cond_start | cond_stop;
    end
  end

  // release lands early in the first clock-low half after a start, before the first rising clock
  assign link_rst_b = rst_b_i & ~frame_clr_q;

  // strap is static; two link-clock flops settle it within two bits
  always_ff @(posedge scl or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_meta_q <= 1'b0;
      strap_q      <= 1'b0;
    end
    else
    begin
      strap_meta_q <= slave_address_select_pin_i;
      strap_q      <= strap_meta_q;
    end
  end

  // decode at the acknowledge slot
  assign at_ack   = (cnt_q == IRSP_ACK_SLOT);
  assign addr_hit = (shift_q[7:1] == {IRSP_ADDR_UPPER, strap_q});
  // each complete data byte becomes a write
  assign issue_wr = at_ack & (state_q == ST_WDATA);
  // fetch on read address, then on each master acknowledge
  assign issue_rd = at_ack
                  & (((state_q == ST_ADDR) & addr_hit & shift_q[0])
                  |  ((state_q == ST_RDATA) & ~sda_in));

  // bit counter and shift-in on rising link clock
  always_ff @(posedge scl or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      cnt_q   <= IRSP_CNT_RST;
      shift_q <= IRSP_SHIFT_RST;
    end
    else if (!at_ack)
    begin
      shift_q <= {shift_q[IRSP_BYTE_W-2:0], sda_in};
      cnt_q   <= cnt_q + 4'h1;
    end
    else
    begin
      cnt_q <= IRSP_CNT_RST;
    end
  end

  // byte phase sequencing, one step per acknowledge slot
  always_ff @(posedge scl or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      state_q <= ST_ADDR;
    end
    else if (at_ack)
    begin
      case (state_q)
        ST_ADDR:
        begin
          if (!addr_hit)
            state_q <= ST_IGNORE;
          else if (shift_q[0])
            state_q <= ST_RDATA;
          else
            state_q <= ST_SUB;
        end
        ST_SUB:
        begin
          state_q <= ST_WDATA;
        end
        ST_WDATA:
        begin
          state_q <= ST_WDATA;
        end
        ST_RDATA:
        begin
          if (sda_in)
            state_q <= ST_IGNORE;
        end
        default:
        begin
          state_q <= ST_IGNORE;
        end
      endcase
    end
  end

  // register pointer survives stop so phase two reads from phase one
  always_ff @(posedge scl or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ptr_q <= IRSP_PTR_RST;
    end
    else if (at_ack && state_q == ST_SUB && link_rst_b)
    begin
      ptr_q <= shift_q;
    end
    else if ((issue_wr || issue_rd) && link_rst_b)
    begin
      ptr_q <= ptr_q + IRSP_PTR_STEP;
    end
  end

  // request word is frozen until the next acknowledge slot, which the
  // stretched clock cannot reach before the core has answered
  always_ff @(posedge scl or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      req_q     <= IRSP_REQ_RST;
      req_tgl_q <= 1'b0;
    end
    else if ((issue_wr || issue_rd) && link_rst_b)
    begin
      req_q.we   <= issue_wr;
      req_q.addr <= ptr_q;
      req_q.data <= shift_q;
      req_tgl_q  <= ~req_tgl_q;
    end
  end

  // acknowledge every byte of an addressed write and the read address
  assign ack_due = at_ack
                 & (((state_q == ST_ADDR) & addr_hit)
                 | (state_q == ST_SUB)
                 | (state_q == ST_WDATA));

  // data line changes only while the link clock is low: on its falling edge, or when read data lands during a stretch
  always_ff @(negedge scl or negedge link_rst_b)
  begin
    if (!link_rst_b)
    begin
      drive_ack_q <= 1'b0;
      rd_phase_q  <= 1'b0;
      idx_q       <= IRSP_IDX_RST;
    end
    else
    begin
      drive_ack_q <= ack_due;
      // released in the master acknowledge slot and after a not-acknowledge
      rd_phase_q  <= (state_q == ST_RDATA) & ~at_ack;
      idx_q       <= cnt_q[2:0];
    end
  end

  // open-drain data: only ever pulled low
  // read byte sent MSB first from the held read word
  assign serial_data_pin_o    = 1'b0;
  assign serial_data_pin_oe_o = drive_ack_q
                              | (rd_phase_q & ~rd_data_q[IRSP_MSB_IDX - idx_q]);

  // request outstanding while the toggles differ
  assign busy        = req_tgl_s ^ ack_tgl_q;
  assign reg_valid_o = busy;
  assign reg_req_o   = req_q;

  // hold clock low until the core has taken the access
  assign serial_clock_pin_o    = 1'b0;
  assign serial_clock_pin_oe_o = busy;

  // complete the handshake and hold read data for the link side
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_tgl_q <= 1'b0;
      rd_data_q <= IRSP_RDATA_RST;
    end
    else if (ce_i && busy && reg_ready_i)
    begin
      ack_tgl_q <= ~ack_tgl_q;
      if (!req_q.we)
        rd_data_q <= reg_rdata_i;
    end
  end

endmodule // irsp_slave_port

// File: testbench/irsp_chk.sv
module irsp_chk
(
  input wire logic                   mclk_i,                // clock
  input wire logic                   rst_b_i,               // reset
  input wire logic                   ce_i,                  // enable
  input wire logic                   serial_clock_pin_i,    // scl line
  input wire logic                   serial_clock_pin_o,    // scl level
  input wire logic                   serial_clock_pin_oe_o, // stretch
  input wire logic                   serial_data_pin_o,     // sda level
  input wire logic                   serial_data_pin_oe_o,  // sda pull
  input wire irsp_pkg::irsp_req_type reg_req_o,             // request
  input wire logic                   reg_valid_o,           // pending
  input wire logic                   reg_ready_i            // taken
);
  timeunit 1ns;
  timeprecision 100ps;
  import irsp_pkg::*;
  // an access is taken only while enabled
  wire logic acc = reg_valid_o & reg_ready_i & ce_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  AST_SCL_OD: assert property (serial_clock_pin_o == 1'b0)
    else $error("clock pin driven high");
  AST_SDA_OD: assert property (serial_data_pin_o == 1'b0)
    else $error("data pin driven high");
  AST_HOLD: assert property (reg_valid_o && !acc |=> reg_valid_o && $stable(reg_req_o))
    else $error("request moved before accept");
  AST_DROP: assert property (acc |=> !reg_valid_o)
    else $error("request stayed after accept");
  AST_STRETCH: assert property (reg_valid_o |-> serial_clock_pin_oe_o && !serial_clock_pin_i)
    else $error("pending access without stretch");
  AST_FREE: assert property (acc |=> !serial_clock_pin_oe_o)
    else $error("stretch outlived request");
  AST_SDA_LOW: assert property (!$stable(serial_data_pin_oe_o) |-> !serial_clock_pin_i)
    else $error("data changed with clock high");
  AST_QUIET: assert property ($rose(rst_b_i) |-> !reg_valid_o && !serial_data_pin_oe_o)
    else $error("busy right after reset");
  // main traffic
  COV_WR: cover property (acc && reg_req_o.we);
  COV_RD: cover property (acc && !reg_req_o.we);
  COV_LONG: cover property (serial_clock_pin_oe_o [*3]);
endmodule // irsp_chk

// File: testbench/irsp_mst.sv
module irsp_mst
(
  output logic      scl_o = 1'b1, // 1 releases
  output logic      sda_o = 1'b1, // 1 releases
  input  wire logic scl_i,        // clock line
  input  wire logic sda_i         // data line
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic rise();
    scl_o = 1'b1;
    #1;
    while (scl_i !== 1'b1)
      #1;
  endtask
  // half-ns offset keeps edges off the core grid when start is called just after a core clock edge
  task automatic start();
    #0.5;
    sda_o = 1'b1;
    rise();
    #16;
    sda_o = 1'b0;
    #16;
  endtask
  task automatic bitx(input logic b, output logic r);
    scl_o = 1'b0;
    #13;
    sda_o = b;
    #13;
    rise();
    #3;
    r = sda_i;
    #2;
  endtask
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, a);
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
  task automatic stop();
    scl_o = 1'b0;
    #13;
    sda_o = 1'b0;
    #13;
    rise();
    #16;
    sda_o = 1'b1;
    #16;
  endtask
endmodule // irsp_mst

// File: testbench/irsp_slave_port_tb.sv
module irsp_slave_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irsp_pkg::*;
  logic         mclk  = 1'b0;
  logic         rst_b = 1'b0;
  logic         ce    = 1'b0;
  logic         strap = 1'b0;
  logic         ready = 1'b0;
  logic [7:0]   rdata = 8'h00;
  logic [7:0]   mem [256];
  logic [7:0]   exp_mem [256];
  logic [16:0]  q [$];
  int           bad_count   = 0;
  int           checks_done = 0;
  int           cyc         = 0;
  wire logic    m_scl;
  wire logic    m_sda;
  wire logic    scl_oe;
  wire logic    sda_oe;
  wire logic    valid;
  irsp_req_type req;
  // open-drain lines with pull-ups
  wire logic    scl = m_scl & ~scl_oe;
  wire logic    sda = m_sda & ~sda_oe;
  always #2 mclk = ~mclk;
  irsp_slave_port i_dut
  (
    .mclk_i(mclk),
    .rst_b_i(rst_b),
    .ce_i(ce),
    .serial_clock_pin_i(scl),
    .serial_clock_pin_o(),
    .serial_clock_pin_oe_o(scl_oe),
    .serial_data_pin_i(sda),
    .serial_data_pin_o(),
    .serial_data_pin_oe_o(sda_oe),
    .slave_address_select_pin_i(strap),
    .reg_req_o(req),
    .reg_valid_o(valid),
    .reg_ready_i(ready),
    .reg_rdata_i(rdata)
  );
  irsp_mst i_mst
  (
    .scl_o(m_scl),
    .sda_o(m_sda),
    .scl_i(scl),
    .sda_i(sda)
  );
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // address nobody here owns: no ack, no access
  task automatic foreign(input logic [7:0] adr);
    logic a;
    @(negedge mclk);
    i_mst.start();
    i_mst.wr(adr, a);
    chk(17'(a), 17'h0_0001);
    i_mst.stop();
  endtask
  // write n random bytes from sub; n of 0 is read phase one
  task automatic wr_frame(input logic [7:0] sub, input int n);
    logic       a;
    logic [7:0] d;
    logic [7:0] p;
    p = sub;
    @(negedge mclk);
    i_mst.start();
    i_mst.wr({IRSP_ADDR_UPPER, strap, 1'b0}, a);
    chk(17'(a), 17'h0_0000);
    i_mst.wr(sub, a);
    chk(17'(a), 17'h0_0000);
    repeat (n)
    begin
      d = 8'($urandom);
      exp_mem[p] = d;
      q.push_back({1'b1, p, d});
      i_mst.wr(d, a);
      chk(17'(a), 17'h0_0000);
      p++;
    end
    i_mst.stop();
  endtask
  // notes go first: the first fetch rides the address ack
  task automatic rd_frame(input logic [7:0] sub, input int n);
    logic       a;
    logic [7:0] d;
    wr_frame(sub, 0);
    for (int k = 0; k < n; k++)
      q.push_back({1'b0, 8'(sub + k), 8'h00});
    i_mst.start();
    i_mst.wr({IRSP_ADDR_UPPER, strap, 1'b1}, a);
    chk(17'(a), 17'h0_0000);
    for (int k = 0; k < n; k++)
    begin
      i_mst.rd(k == n - 1, d);
      chk(17'(d), 17'(exp_mem[8'(sub + k)]));
    end
    #8;
    chk(17'(sda_oe), 17'h0_0000);
    // device must stay off the data line once the clock falls again
    fork
      i_mst.stop();
      begin
        #20;
        chk(17'(sda_oe), 17'h0_0000);
      end
    join
  endtask
  always @(negedge mclk)
  begin
    ce <= ($urandom % 8) != 0;
    ready <= ($urandom % 4) != 0;
    rdata <= mem[req.addr];
  end
  // each accepted access retires the oldest note
  always @(posedge mclk)
  begin
    if (rst_b && ce && valid && ready)
    begin
      if (req.we)
        mem[req.addr] = req.data;
      if (q.size() == 0)
        chk(17'(q.size()), 17'h0_0001);
      else
        chk({req.we, req.addr, req.we ? req.data : 8'h00}, q.pop_front());
    end
  end
  // hang guard, well above the run length
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(98));
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    for (int s = 0; s < 2; s++)
    begin
      strap = 1'(s);
      foreign({6'h2c, strap, 1'b0});
      foreign({IRSP_ADDR_UPPER, ~strap, 1'b0});
      wr_frame(8'h7f, 1);
      wr_frame(8'hfe, 3);
      rd_frame(8'hfe, 3);
      rd_frame(8'h7f, 1);
    end
    chk(17'(q.size()), 17'h0_0000);
    report_and_stop();
  end
endmodule // irsp_slave_port_tb
bind irsp_slave_port irsp_chk i_chk
(
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .serial_clock_pin_i(serial_clock_pin_i),
  .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe_o(serial_clock_pin_oe_o),
  .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe_o(serial_data_pin_oe_o),
  .reg_req_o(reg_req_o), .reg_valid_o(reg_valid_o), .reg_ready_i(reg_ready_i)
);
